// >>> rtl/tfg_top.sv
// Transmit frame generator for one T1/J1 link with an AHB-Lite slave.
`timescale 1ns/1ps
// Notes on behaviour
// - Four formats SF, ESF, DM, SLC-96; insertion only while framing enabled.
// - SF overwrites every F-bit with the 12-bit alignment sequence, except the twelfth in J1.
// - J1 SF drives the twelfth F-bit low without yellow alarm.
// - SF and DM inject one odd-frame or one even-frame F-bit error.
// - Copy enable repeats each F-bit in the following bit.
// - Yellow alarm sent manually or automatically on receive red alarm.
// - T1 SF and SLC yellow forces channel bit 2 low; J1 twelfth F high.
// - ESF places 001011 into F-bits of frames 4, 8 up to 24.
// - ESF frame sync invert flips exactly one alignment bit.
// - ESF inserts previous multiframe CRC-6 in frames 2, 6 up to 22.
// - ESF check sequence invert flips one whole CRC word.
// - Link bit priority yellow, code, report, HDLC, idle; bypass gates four.
// - ESF idle code FFFF for T1 and FF7E for J1.
// - ESF yellow repeats FF00 for T1 and FFFF for J1 on link bits.
// - DM overwrites every F-bit with the 12-bit alignment sequence.
// - DM writes DDS pattern into bits 8 and 5..1 of channel 24.
// - DM pattern invert flips one complete DDS pattern.
// - DM carries HDLC data in channel 24 bit 7 unless bypassed.
// - DM channel 24 bit 6 is zero on yellow, otherwise one.
// - SLC writes 24-bit alignment, spoiler and even-frame link bits into F-bits.
// - SLC injects one sync even-frame error or one odd-frame error.
// - SLC link bits come from three software link words unless bypassed.
// - Frame start sets a flag; enabled flag drives the interrupt.
// - Multiframe start sets a flag; enabled flag drives the interrupt.
module tfg_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [tfg_pkg::ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [tfg_pkg::DATA_W-1:0] HWDATA,
    output logic [tfg_pkg::DATA_W-1:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Payload stream
    input wire logic TX_BIT_EN,
    input wire logic TX_DATA,
    // Receive side status
    input wire logic RED_ALARM,
    // Data-link sources
    input wire logic BOC_VALID,
    input wire logic BOC_BIT,
    input wire logic PRM_VALID,
    input wire logic PRM_BIT,
    input wire logic HDLC_VALID,
    input wire logic HDLC_BIT,
    output logic BOC_TAKE,
    output logic PRM_TAKE,
    output logic HDLC_TAKE,
    // Line side
    output logic LINE_DATA,
    output logic LINE_STROBE,
    // Interrupt
    output logic IRQ_N
);
    import tfg_pkg::*;

    // -------------------------------------------------------------------
    // Registers and state
    // -------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_r;
    logic [7:0] link0_r, link1_r, link2_r;
    logic [1:0] ist_r, ien_r;
    logic pend_ft_r, pend_fs_r, pend_crc_r, pend_dds_r;
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic [DATA_W-1:0] rd_val;
    logic red_meta_r, red_sync_r;
    logic [7:0] pos_r;
    logic [6:0] frame_r, mf_len;
    logic [5:0] crc_r, crc_word_r, crc_nxt;
    logic crc_inv_r, dds_inv_r, fbit_r;
    logic [3:0] dl_cnt_r;
    logic out_bit, fbit, yellow, framing_disable, j1, mimic, linkbyp;
    logic use_ft, use_fs, is_dl, mf_start, fr_start, addr_ok;
    logic [2:0] chbit;
    logic [3:0] sf_idx, pat_idx;
    logic [4:0] slc_idx, slc_k;
    logic [6:0] f24;
    logic [23:0] slc_fs_vec;
    logic [15:0] idle_pat, yel_pat;
    tfg_fmt_t fmt;

    assign fmt = tfg_fmt_t'(ctrl_r[CTRL_FMT_LO +: 2]);
    assign framing_disable = ctrl_r[CTRL_FRAMING_DISABLE];
    assign j1 = ctrl_r[CTRL_J1];
    assign mimic = ctrl_r[CTRL_MIMIC];
    assign linkbyp = ctrl_r[CTRL_LINKBYP];
    assign yellow = ctrl_r[CTRL_MANYEL] |
                    (ctrl_r[CTRL_AUTOYEL] & red_sync_r);
    assign chbit = 3'(pos_r - 8'h01);
    assign fr_start = TX_BIT_EN && pos_r == 8'h00;
    assign mf_start = fr_start && frame_r == 7'h00;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign IRQ_N = ~|(ist_r & ien_r);

    // -------------------------------------------------------------------
    // Receive red alarm synchroniser
    // -------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            red_meta_r <= 1'b0;
            red_sync_r <= 1'b0;
        end else begin
            red_meta_r <= RED_ALARM;
            red_sync_r <= red_meta_r;
        end
    end

    // -------------------------------------------------------------------
    // AHB-Lite slave: zero wait states, read data registered
    // -------------------------------------------------------------------
    assign addr_ok = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;

    always_comb begin
        rd_val = '0;
        unique case (HADDR[7:0])
            ADDR_CTRL: rd_val[CTRL_W-1:0] = ctrl_r;
            ADDR_ERRINJ: rd_val[3:0] = {pend_dds_r, pend_crc_r,
                                        pend_fs_r, pend_ft_r};
            ADDR_LINK0: rd_val[7:0] = link0_r;
            ADDR_LINK1: rd_val[7:0] = link1_r;
            ADDR_LINK2: rd_val[7:0] = link2_r;
            ADDR_ISTAT: rd_val[1:0] = ist_r;
            ADDR_IEN: rd_val[1:0] = ien_r;
            ADDR_STAT: begin
                rd_val[7:0] = pos_r;
                rd_val[STAT_FRAME_LO +: 7] = frame_r;
                rd_val[STAT_YEL] = yellow;
                rd_val[STAT_RED] = red_sync_r;
            end
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
            HRDATA <= '0;
        end else begin
            wr_pend_r <= addr_ok && HWRITE;
            if (addr_ok) begin
                addr_r <= HADDR[7:0];
            end
            if (addr_ok && !HWRITE) begin
                HRDATA <= rd_val;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_r <= CTRL_RST;
            link0_r <= 8'h00;
            link1_r <= 8'h00;
            link2_r <= 8'h00;
            ien_r <= 2'h0;
        end else if (wr_pend_r) begin
            if (addr_r == ADDR_CTRL) begin
                ctrl_r <= HWDATA[CTRL_W-1:0];
            end
            if (addr_r == ADDR_LINK0) begin
                link0_r <= HWDATA[7:0];
            end
            if (addr_r == ADDR_LINK1) begin
                link1_r <= HWDATA[7:0];
            end
            if (addr_r == ADDR_LINK2) begin
                link2_r <= HWDATA[7:0];
            end
            if (addr_r == ADDR_IEN) begin
                ien_r <= HWDATA[1:0];
            end
        end
    end

    // Sticky start flags: a set in the clearing cycle wins.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ist_r <= 2'h0;
        end else begin
            ist_r <= (ist_r & ~((wr_pend_r && addr_r == ADDR_ISTAT) ?
                      HWDATA[1:0] : 2'h0)) | {mf_start, fr_start};
        end
    end

    // One-shot error requests: written high, cleared when applied unless an error-inject write lands in that same cycle.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            pend_ft_r <= 1'b0;
            pend_fs_r <= 1'b0;
            pend_crc_r <= 1'b0;
            pend_dds_r <= 1'b0;
        end else begin
            if (TX_BIT_EN && pos_r == 8'h00 && use_ft) begin
                pend_ft_r <= 1'b0;
            end
            if (TX_BIT_EN && pos_r == 8'h00 && use_fs) begin
                pend_fs_r <= 1'b0;
            end
            if (mf_start && fmt == TFG_ESF && !framing_disable) begin
                pend_crc_r <= 1'b0;
            end
            if (fr_start && fmt == TFG_DM && !framing_disable) begin
                pend_dds_r <= 1'b0;
            end
            if (wr_pend_r && addr_r == ADDR_ERRINJ) begin
                pend_ft_r <= pend_ft_r | HWDATA[ERR_FT];
                pend_fs_r <= pend_fs_r | HWDATA[ERR_FS];
                pend_crc_r <= pend_crc_r | HWDATA[ERR_CRC];
                pend_dds_r <= pend_dds_r | HWDATA[ERR_DDS];
            end
        end
    end

    // -------------------------------------------------------------------
    // Bit and frame position counters
    // -------------------------------------------------------------------
    always_comb begin
        unique case (fmt)
            TFG_ESF: mf_len = MF_LEN_ESF;
            TFG_SLC: mf_len = MF_LEN_SLC;
            TFG_SF, TFG_DM: mf_len = MF_LEN_SF;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            pos_r <= 8'h00;
            frame_r <= 7'h00;
        end else if (TX_BIT_EN) begin
            if (pos_r == LAST_BIT) begin
                pos_r <= 8'h00;
                frame_r <= (frame_r >= mf_len - 7'h01) ? 7'h00 :
                           frame_r + 7'h01;
            end else begin
                pos_r <= pos_r + 8'h01;
            end
        end
    end

    // -------------------------------------------------------------------
    // ESF CRC-6, link pattern counter and per-pattern invert latches
    // -------------------------------------------------------------------
    assign crc_nxt = {crc_r[4:0], 1'b0} ^
                     ((crc_r[5] ^ (pos_r == 8'h00 ? 1'b1 : out_bit)) ?
                      CRC_POLY : 6'h00);

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            crc_r <= 6'h00;
            crc_word_r <= 6'h00;
            crc_inv_r <= 1'b0;
            dds_inv_r <= 1'b0;
            dl_cnt_r <= 4'h0;
        end else if (TX_BIT_EN) begin
            if (mf_start) begin
                crc_word_r <= crc_r;
                crc_inv_r <= pend_crc_r;
                crc_r <= {CRC_POLY[5:1], 1'b0} & 6'h00 ^
                         (1'b1 ? CRC_POLY : 6'h00);
            end else begin
                crc_r <= crc_nxt;
            end
            if (fr_start) begin
                dds_inv_r <= pend_dds_r;
            end
            if (is_dl) begin
                dl_cnt_r <= dl_cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            fbit_r <= 1'b0;
            LINE_DATA <= 1'b0;
            LINE_STROBE <= 1'b0;
        end else begin
            LINE_STROBE <= TX_BIT_EN;
            if (TX_BIT_EN) begin
                LINE_DATA <= out_bit;
                if (pos_r == 8'h00) begin
                    fbit_r <= out_bit;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Overhead insertion
    // -------------------------------------------------------------------
    assign sf_idx = 4'(SF_LAST_IDX - frame_r[3:0]);
    assign f24 = frame_r >= 7'h30 ? frame_r - 7'h30 :
                 frame_r >= 7'h18 ? frame_r - 7'h18 : frame_r;
    assign slc_idx = 5'(SLC_LAST_IDX - f24[4:0]);
    assign slc_k = 5'((frame_r - SLC_LINK_BASE) >> 1);
    assign slc_fs_vec = {SLC_SPOIL_TAIL, link2_r[5:2], link2_r[1:0],
                         link1_r[5:3], SLC_SPOIL_MID, link1_r[2:0],
                         link0_r};
    assign idle_pat = j1 ? IDLE_J1 : IDLE_T1;
    assign yel_pat = j1 ? YEL_J1 : YEL_T1;
    assign pat_idx = 4'(4'hf - dl_cnt_r);
    assign is_dl = fr_start && !framing_disable && fmt == TFG_ESF && !frame_r[0];

    always_comb begin
        fbit = TX_DATA;
        use_ft = 1'b0;
        use_fs = 1'b0;
        BOC_TAKE = 1'b0;
        PRM_TAKE = 1'b0;
        HDLC_TAKE = 1'b0;
        unique case (fmt)
            TFG_SF, TFG_DM: begin
                fbit = SF_ALIGN[sf_idx];
                if (fmt == TFG_SF && j1 && frame_r == 7'(SF_LAST_IDX)) begin
                    fbit = yellow;
                end
                use_ft = pend_ft_r && !frame_r[0];
                use_fs = pend_fs_r && frame_r[0];
            end
            TFG_ESF: begin
                if (frame_r[1:0] == 2'h3) begin
                    fbit = ESF_ALIGN[3'(ESF_LAST_IDX - 3'(frame_r[6:2]))];
                    use_fs = pend_fs_r;
                end else if (frame_r[1:0] == 2'h1) begin
                    if (!ctrl_r[CTRL_CHECK_SEQUENCE_BYPASS]) begin
                        fbit = crc_word_r[3'(ESF_LAST_IDX -
                                             3'(frame_r[6:2]))] ^
                               crc_inv_r;
                    end
                end else if (yellow) begin
                    fbit = yel_pat[pat_idx];
                end else if (!linkbyp) begin
                    if (BOC_VALID) begin
                        fbit = BOC_BIT;
                        BOC_TAKE = TX_BIT_EN && pos_r == 8'h00 && !framing_disable;
                    end else if (PRM_VALID) begin
                        fbit = PRM_BIT;
                        PRM_TAKE = TX_BIT_EN && pos_r == 8'h00 && !framing_disable;
                    end else if (HDLC_VALID) begin
                        fbit = HDLC_BIT;
                        HDLC_TAKE = TX_BIT_EN && pos_r == 8'h00 && !framing_disable;
                    end else begin
                        fbit = idle_pat[pat_idx];
                    end
                end
            end
            TFG_SLC: begin
                if (!frame_r[0] || frame_r < SLC_SYNC_END) begin
                    fbit = SLC_ALIGN[slc_idx];
                    use_ft = pend_ft_r && !frame_r[0];
                    use_fs = pend_fs_r && frame_r[0];
                end else if (!linkbyp || slc_k == 5'h0b || slc_k > 5'h14) begin
                    fbit = slc_fs_vec[slc_k];
                end
            end
        endcase
        fbit = fbit ^ use_ft ^ use_fs;
        out_bit = TX_DATA;
        if (!framing_disable) begin
            if (pos_r == 8'h00) begin
                out_bit = fbit;
            end else if (pos_r == 8'h01 && mimic) begin
                out_bit = fbit_r;
            end else if (fmt == TFG_DM && pos_r >= CH24_FIRST) begin
                if (DDS_MASK[chbit]) begin
                    out_bit = DDS_PAT[chbit] ^ dds_inv_r;
                end else if (chbit == BIT6_OF_CH) begin
                    out_bit = !yellow;
                end else if (!linkbyp && HDLC_VALID) begin
                    out_bit = HDLC_BIT;
                    HDLC_TAKE = TX_BIT_EN;
                end
            end else if (chbit == BIT2_OF_CH && yellow &&
                         (fmt == TFG_SLC || (fmt == TFG_SF && !j1))) begin
                out_bit = 1'b0;
            end
        end else begin
            use_ft = 1'b0;
            use_fs = 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    logic dds_exp, idle_bit, crc_bit, sf_exp;
    assign dds_exp = DDS_PAT[chbit];
    assign idle_bit = idle_pat[pat_idx];
    assign crc_bit = crc_word_r[3'(ESF_LAST_IDX - 3'(frame_r[6:2]))];
    assign sf_exp = SF_ALIGN[sf_idx];

    sequence s_fslot;
        TX_BIT_EN && pos_r == 8'h00 && !framing_disable;
    endsequence
    sequence s_mimic_slot;
        TX_BIT_EN && pos_r == 8'h01 && mimic && !framing_disable;
    endsequence

    a_pass_through: assert property (
        TX_BIT_EN && framing_disable |=> LINE_STROBE && LINE_DATA == $past(TX_DATA))
        else $error("bit altered while framing disabled");
    a_sf_align_bit: assert property (
        s_fslot ##0 (fmt == TFG_SF && !j1 && !pend_ft_r && !pend_fs_r)
        |=> LINE_DATA == $past(sf_exp))
        else $error("SF alignment bit wrong");
    a_mimic_copy: assert property (
        s_mimic_slot |=> LINE_DATA == $past(fbit_r))
        else $error("mimic bit differs from F-bit");
    a_t1_yellow_bit: assert property (
        TX_BIT_EN && !framing_disable && yellow && chbit == BIT2_OF_CH &&
        pos_r != 8'h01 && (fmt == TFG_SLC || (fmt == TFG_SF && !j1))
        |=> !LINE_DATA)
        else $error("yellow bit 2 not low");
    a_dm_y_bit: assert property (
        TX_BIT_EN && !framing_disable && fmt == TFG_DM && pos_r >= CH24_FIRST &&
        chbit == BIT6_OF_CH |=> LINE_DATA == !$past(yellow))
        else $error("DM Y bit wrong");
    a_dm_dds_bit: assert property (
        TX_BIT_EN && !framing_disable && fmt == TFG_DM && pos_r >= CH24_FIRST &&
        DDS_MASK[chbit] && !dds_inv_r |=> LINE_DATA == $past(dds_exp))
        else $error("DDS bit wrong");
    a_esf_idle_code: assert property (
        s_fslot ##0 (fmt == TFG_ESF && !frame_r[0] && !yellow && !linkbyp &&
        !BOC_VALID && !PRM_VALID && !HDLC_VALID)
        |=> LINE_DATA == $past(idle_bit))
        else $error("idle code bit wrong");
    a_esf_crc_bit: assert property (
        s_fslot ##0 (fmt == TFG_ESF && frame_r[1:0] == 2'h1 &&
        !ctrl_r[CTRL_CHECK_SEQUENCE_BYPASS] && !crc_inv_r)
        |=> LINE_DATA == $past(crc_bit))
        else $error("CRC bit wrong");
    a_frame_flag_set: assert property (
        TX_BIT_EN && pos_r == 8'h00 |=> ist_r[IRQ_FRAME])
        else $error("frame start flag not set");
    a_mframe_irq: assert property (
        mf_start && ien_r[IRQ_MFRAME] && !wr_pend_r |=> !IRQ_N [*2])
        else $error("multiframe interrupt missing");

endmodule // tfg_top

// >>> rtl/tfg_pkg.sv
// Constants, register map and types for the T1/J1 transmit frame generator.
package tfg_pkg;

    // -------------------------------------------------------------------
    // Bus and register map
    // -------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ERRINJ = 8'h04;
    localparam logic [7:0] ADDR_LINK0 = 8'h08;
    localparam logic [7:0] ADDR_LINK1 = 8'h0c;
    localparam logic [7:0] ADDR_LINK2 = 8'h10;
    localparam logic [7:0] ADDR_ISTAT = 8'h14;
    localparam logic [7:0] ADDR_IEN = 8'h18;
    localparam logic [7:0] ADDR_STAT = 8'h1c;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // -------------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------------
    localparam int CTRL_FMT_LO = 0;
    localparam int CTRL_J1 = 2;
    localparam int CTRL_FRAMING_DISABLE = 3;
    localparam int CTRL_CHECK_SEQUENCE_BYPASS = 4;
    localparam int CTRL_LINKBYP = 5;
    localparam int CTRL_MIMIC = 6;
    localparam int CTRL_MANYEL = 7;
    localparam int CTRL_AUTOYEL = 8;
    localparam int CTRL_W = 9;
    localparam logic [8:0] CTRL_RST = 9'h008;
    localparam int ERR_FT = 0;
    localparam int ERR_FS = 1;
    localparam int ERR_CRC = 2;
    localparam int ERR_DDS = 3;
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_MFRAME = 1;
    localparam int STAT_FRAME_LO = 8;
    localparam int STAT_YEL = 16;
    localparam int STAT_RED = 17;

    // -------------------------------------------------------------------
    // Frame geometry and patterns
    // -------------------------------------------------------------------
    localparam logic [7:0] LAST_BIT = 8'hc0;
    localparam logic [7:0] CH24_FIRST = 8'hb9;
    localparam logic [6:0] MF_LEN_SF = 7'h0c;
    localparam logic [6:0] MF_LEN_ESF = 7'h18;
    localparam logic [6:0] MF_LEN_SLC = 7'h48;
    localparam logic [6:0] SLC_SYNC_END = 7'h18;
    localparam logic [6:0] SLC_LINK_BASE = 7'h19;
    localparam logic [3:0] SF_LAST_IDX = 4'hb;
    localparam logic [4:0] SLC_LAST_IDX = 5'h17;
    localparam logic [2:0] ESF_LAST_IDX = 3'h5;
    localparam logic [2:0] BIT2_OF_CH = 3'h1;
    localparam logic [2:0] BIT6_OF_CH = 3'h5;
    localparam logic [2:0] BIT7_OF_CH = 3'h6;
    localparam logic [11:0] SF_ALIGN = 12'h8dc;
    localparam logic [5:0] ESF_ALIGN = 6'h0b;
    localparam logic [23:0] SLC_ALIGN = 24'h237237;
    localparam logic [15:0] IDLE_T1 = 16'hffff;
    localparam logic [15:0] IDLE_J1 = 16'hff7e;
    localparam logic [15:0] YEL_T1 = 16'hff00;
    localparam logic [15:0] YEL_J1 = 16'hffff;
    localparam logic [7:0] DDS_PAT = 8'h1d;
    localparam logic [7:0] DDS_MASK = 8'h9f;
    localparam logic [5:0] CRC_POLY = 6'h03;
    localparam logic SLC_SPOIL_MID = 1'b0;
    localparam logic [2:0] SLC_SPOIL_TAIL = 3'h5;

    typedef enum logic [1:0] {
        TFG_SF = 2'b00,
        TFG_ESF = 2'b01,
        TFG_DM = 2'b10,
        TFG_SLC = 2'b11
    } tfg_fmt_t;

endpackage

// >>> tb/tfg_remote_model.sv
// Remote terminal model that collects received F-bits and channel bytes.
`timescale 1ns/1ps
module tfg_remote_model (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Line side
    input wire logic line_data,
    input wire logic line_strobe,
    // Captured bits
    output logic [23:0] fsr,
    output logic [7:0] ch1,
    output logic [7:0] ch24
);
    logic [7:0] pos_r;
    // Counts line bits and keeps the F-bit history, channel 1 and channel 24.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pos_r <= 8'h00;
            fsr <= 24'h000000;
            ch1 <= 8'h00;
            ch24 <= 8'h00;
        end else if (line_strobe) begin
            pos_r <= (pos_r == 8'hc0) ? 8'h00 : pos_r + 8'h01;
            if (pos_r == 8'h00) fsr <= {fsr[22:0], line_data};
            if (pos_r > 8'h00 && pos_r < 8'h09) ch1 <= {ch1[6:0], line_data};
            if (pos_r > 8'hb8) ch24 <= {ch24[6:0], line_data};
        end
    end
endmodule // tfg_remote_model

// >>> tb/test_t1_j1_frame_generator.sv
// Testbench for the T1/J1 transmit frame generator.
`timescale 1ns/1ps
module test_t1_j1_frame_generator;
    import tfg_pkg::*;
    logic CLOCK = 0, RESETN = 0, HSEL = 0, HWRITE = 0;
    logic TX_BIT_EN = 0, TX_DATA = 1, RED_ALARM = 0, SRC_V = 0;
    logic [31:0] HADDR = 0, HWDATA = 0, q, HRDATA;
    logic [1:0] HTRANS = 0;
    logic HREADYOUT, HRESP, LINE_DATA, LINE_STROBE, IRQ_N;
    logic BOC_TAKE, PRM_TAKE, HDLC_TAKE;
    logic [2:0] take_seen = 0;
    logic [23:0] fsr;
    logic [7:0] ch1, ch24;
    int miscompares = 0, n_checks = 0;
    always #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) TX_BIT_EN <= RESETN;
    always @(posedge CLOCK) begin
        take_seen <= take_seen | {HDLC_TAKE, PRM_TAKE, BOC_TAKE};
    end
    tfg_top tfg_top_i (.CLOCK(CLOCK), .RESETN(RESETN), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TX_BIT_EN(TX_BIT_EN),
        .TX_DATA(TX_DATA), .RED_ALARM(RED_ALARM), .BOC_VALID(SRC_V),
        .BOC_BIT(TX_DATA), .PRM_VALID(SRC_V), .PRM_BIT(TX_DATA),
        .HDLC_VALID(SRC_V), .HDLC_BIT(TX_DATA), .BOC_TAKE(BOC_TAKE),
        .PRM_TAKE(PRM_TAKE), .HDLC_TAKE(HDLC_TAKE),
        .LINE_DATA(LINE_DATA), .LINE_STROBE(LINE_STROBE),
        .IRQ_N(IRQ_N));
    tfg_remote_model tfg_remote_model_i (.clock(CLOCK), .resetn(RESETN),
        .line_data(LINE_DATA), .line_strobe(LINE_STROBE), .fsr(fsr),
        .ch1(ch1), .ch24(ch24));
    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic rdy();
        int k = 0;
        do begin
            @(posedge CLOCK);
            k++;
        end while (HREADYOUT !== 1'b1 && k < 50);
        if (HREADYOUT !== 1'b1) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= w;
        HADDR <= {24'h000000, a};
        rdy();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        rdy();
        q = HRDATA;
    endtask
    task automatic poll(input int idx, input int p);
        int k = 0;
        do begin
            bus(1'b0, ADDR_STAT, 32'h0);
            k++;
        end while (!(q[14:8] == idx && q[7:0] >= p) && k < 9000);
        if (k >= 9000) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic fchk(input int len, input logic [23:0] e);
        poll(len - 1, 0);
        poll(0, 0);
        poll(len - 1, 100);
        chk({8'h0, fsr} & ((32'h1 << len) - 1), {8'h0, e});
    endtask
    task automatic run(input logic [31:0] c, input int len,
                       input logic [23:0] e);
        bus(1'b1, ADDR_CTRL, c);
        poll(0, 0);
        fchk(len, e);
        $display("test ctrl %h done", c);
    endtask
    initial begin
        repeat (16) @(posedge CLOCK);
        RESETN <= 1'b1;
        @(posedge CLOCK);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(q, 32'h8);
        chk({HREADYOUT, HRESP}, 32'h2);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        run(32'h8, 12, 24'hfff);
        run(32'h0, 12, 24'h8dc);
        bus(1'b1, ADDR_ERRINJ, 32'h1);
        fchk(12, 24'h0dc);
        bus(1'b1, ADDR_ERRINJ, 32'h2);
        fchk(12, 24'hcdc);
        $display("test error injection done");
        run(32'h40, 12, 24'h8dc);
        chk(ch1, 8'h7f);
        run(32'h80, 12, 24'h8dc);
        chk(ch1, 8'hbf);
        run(32'h4, 12, 24'h8dc);
        run(32'h84, 12, 24'h8dd);
        RED_ALARM <= 1'b1;
        run(32'h104, 12, 24'h8dd);
        RED_ALARM <= 1'b0;
        run(32'h22, 12, 24'h8dc);
        chk(ch24, 8'hbe);
        run(32'ha2, 12, 24'h8dc);
        chk(ch24, 8'hba);
        run(32'h31, 24, 24'heefeff);
        poll(0, 50);
        bus(1'b1, ADDR_IEN, 32'h0);
        bus(1'b1, ADDR_ISTAT, 32'h3);
        bus(1'b0, ADDR_ISTAT, 32'h0);
        chk(q, 32'h0);
        @(posedge CLOCK);
        chk(IRQ_N, 1'b1);
        poll(1, 50);
        bus(1'b0, ADDR_ISTAT, 32'h0);
        chk(q, 32'h1);
        bus(1'b1, ADDR_IEN, 32'h3);
        @(posedge CLOCK);
        chk(IRQ_N, 1'b0);
        bus(1'b1, ADDR_CTRL, 32'h11);
        SRC_V <= 1'b1;
        poll(0, 50);
        bus(1'b0, ADDR_ISTAT, 32'h0);
        chk(q, 32'h3);
        chk(take_seen, 32'h1);
        $display("test interrupt done");
        stop_test();
    end
endmodule // test_t1_j1_frame_generator
